// file: rtl/clock_meter.v
// Purpose: measure a highway clock as edges per window, or absent code
// Assumes: clock input already synchronised to clk
// Notes:   window long vs highway periods; code is raw edge count
`timescale 1ns/10ps
`include "host_port_regs.vh"
module clock_meter #(
	parameter [15:0] WINDOW = `RATE_WINDOW_CYC
) (
	input  wire        clk,
	input  wire        reset,
	input  wire        pcm_clk_sync,
	output reg  [15:0] code_ff
);
	reg        last_ff;
	reg [15:0] win_ff;
	reg [15:0] edges_ff;
	wire       rise = pcm_clk_sync & ~last_ff;
	always @(posedge clk) begin
		if (reset) begin
			last_ff  <= 1'b0;
			win_ff   <= 16'h0000;
			edges_ff <= 16'h0000;
			code_ff  <= `CLK_ABSENT_CODE;
		end else begin
			last_ff <= pcm_clk_sync;
			if (win_ff == WINDOW - 16'h0001) begin
				win_ff   <= 16'h0000;
				edges_ff <= 16'h0000;
				code_ff  <= (edges_ff == 16'h0000 && !rise) ? `CLK_ABSENT_CODE :
					edges_ff + {15'h0000, rise};
			end else begin
				win_ff   <= win_ff + 16'h0001;
				edges_ff <= edges_ff + {15'h0000, rise};
			end
		end
	end
endmodule // clock_meter

// file: rtl/host_port_command_check.v
// Purpose: host command register, page, wait pin and clock word read-out
// Assumes: host strobes are synchronous single-cycle pulses on clk
// Notes:   bus mode sampled from config pins at reset release
`timescale 1ns/10ps
`include "host_port_regs.vh"
module host_port_command_check (
	input  wire        clk,
	input  wire        reset,
	input  wire [2:0]  config_pins,
	input  wire        host_addr,
	input  wire        host_wr,
	input  wire        host_rd,
	input  wire [15:0] host_wdata,
	output reg  [15:0] host_rdata_ff,
	output reg         host_rvalid_ff,
	output wire        host_wait_pin,
	output wire        host_int_n,
	input  wire        int_pending,
	output wire        int_ind_read,
	output reg  [15:0] other_cmd_ff,
	output reg         other_cmd_valid_ff,
	input  wire        highway_a_clock_in,
	input  wire        redundant_highway_clock_in,
	input  wire        redundant_highway_frame_in,
	input  wire        test_reset_n,
	output wire        debug_reset,
	output reg  [7:0]  page_ff,
	output reg  [7:0]  if_config_ff,
	output wire        bus_8bit
);
	// ----------------------------------------
	// synchronisers
	// ----------------------------------------
	// every pin-level input crosses two flops before any logic reads it;
	// the straps are included so a strap change near release cannot
	// leave the mode register metastable
	localparam N_ASYNC = 7;
	wire [N_ASYNC-1:0] async_in;
	wire [N_ASYNC-1:0] async_sync;
	assign async_in = {config_pins,
		test_reset_n,
		redundant_highway_frame_in,
		redundant_highway_clock_in,
		highway_a_clock_in};
	genvar gi;
	generate
		for (gi = 0; gi < N_ASYNC; gi = gi + 1) begin : g_sync
			reg [1:0] pipe_ff;
			// only the second flop is read outside this loop
			always @(posedge clk) begin
				pipe_ff <= {pipe_ff[0], async_in[gi]};
			end
			assign async_sync[gi] = pipe_ff[1];
		end
	endgenerate
	wire       hwa_clk_sync;
	wire       red_clk_sync;
	wire       red_frame_sync;
	wire       test_reset_n_sync;
	wire [2:0] config_sync;
	assign hwa_clk_sync      = async_sync[0];
	assign red_clk_sync      = async_sync[1];
	assign red_frame_sync    = async_sync[2];
	assign test_reset_n_sync = async_sync[3];
	assign config_sync       = async_sync[6:4];

	// ----------------------------------------
	// debug port reset
	// ----------------------------------------
	// debug reset hold
	// the synchroniser adds two cycles of lag after the pin falls;
	// the port is also held while the block itself is in reset
	assign debug_reset = reset | ~test_reset_n_sync;

	// ----------------------------------------
	// bus mode strap
	// ----------------------------------------
	reg       rst_d_ff;
	reg [2:0] mode_ff;
	always @(posedge clk) begin
		rst_d_ff <= reset;
		// strap caught at release
		// the straps must already be settled through the synchroniser,
		// so the board has to hold them settled from two cycles before release
		if (rst_d_ff && !reset)
			mode_ff <= config_sync;
	end
	// bit 0 of the strap selects the byte-wide bus
	assign bus_8bit = (mode_ff[0] == 1'b1);

	// ----------------------------------------
	// clock meters
	// ----------------------------------------
	wire [15:0] code_a, code_b;
	wire [15:0] code_a_raw;
	clock_meter u_meter_a (
		.clk          (clk),
		.reset        (reset),
		.pcm_clk_sync (hwa_clk_sync),
		.code_ff      (code_a_raw)
	);
	wire [15:0] code_b_raw;
	clock_meter u_meter_b (
		.clk          (clk),
		.reset        (reset),
		.pcm_clk_sync (red_clk_sync),
		.code_ff      (code_b_raw)
	);
	assign code_a = code_a_raw;
	assign code_b = code_b_raw;
	// a frame seen once is remembered until reset; without any frame
	// both words report the absent code
	reg fs_seen_ff;
	always @(posedge clk)
		if (reset)
			fs_seen_ff <= 1'b0;
		else
			fs_seen_ff <= fs_seen_ff | red_frame_sync;

	// ----------------------------------------
	// command decode
	// ----------------------------------------
	// true when the host address selects the data location
	function is_data;
		input addr;
		begin
			is_data = (addr == `ADDR_DATA);
		end
	endfunction

	reg       wait_ff;
	reg [1:0] words_left_ff;
	reg       byte_sel_ff;
	wire      wr_cmd = host_wr && host_addr == `ADDR_CMD;
	always @(posedge clk) begin
		if (reset) begin
			page_ff            <= 8'h00;
			if_config_ff       <= 8'h00;
			wait_ff            <= 1'b0;
			words_left_ff      <= 2'b00;
			other_cmd_ff       <= 16'h0000;
			other_cmd_valid_ff <= 1'b0;
		end else begin
			other_cmd_valid_ff <= 1'b0;
			if (wr_cmd) begin
				if (host_wdata[15:8] == `CMD_CFG_HI) begin
					if_config_ff <= host_wdata[7:0];
					if (host_wdata[7:0] == `CFG_WAIT_HIGH)
						wait_ff <= 1'b1;
					else if (host_wdata[7:0] == `CFG_WAIT_LOW)
						wait_ff <= 1'b0;
				end else if (host_wdata[15:8] == `CMD_PAGE_HI) begin
					page_ff <= host_wdata[7:0];
				end else begin
					if (host_wdata == `CMD_CLKSEL)
						words_left_ff <= 2'b10;
					other_cmd_ff       <= host_wdata;
					other_cmd_valid_ff <= 1'b1;
				end
			end else if (host_rd && is_data(host_addr) && words_left_ff != 2'b00)
				words_left_ff <= words_left_ff - 2'b01;
		end
	end
	assign host_wait_pin = wait_ff;

	// ----------------------------------------
	// read path
	// ----------------------------------------
	// level pin, active low, follows pending
	assign host_int_n   = ~int_pending;
	// a data read with no clock words left to return is taken as the indication read
	assign int_ind_read = host_rd && is_data(host_addr) && words_left_ff == 2'b00;
	wire [15:0] cmd_word = {page_ff, 6'b00_0000, host_int_n, 1'b0};
	always @(posedge clk) begin
		if (reset) begin
			host_rdata_ff  <= 16'h0000;
			host_rvalid_ff <= 1'b0;
			byte_sel_ff    <= 1'b0;
		end else begin
			host_rvalid_ff <= host_rd;
			if (host_rd && host_addr == `ADDR_CMD) begin
				// low byte then high byte in 8-bit mode
				if (bus_8bit) begin
					host_rdata_ff <= {8'h00, byte_sel_ff ? cmd_word[15:8] : cmd_word[7:0]};
					byte_sel_ff   <= ~byte_sel_ff;
				end else
					host_rdata_ff <= cmd_word;
			end else if (host_rd) begin
				// redundant word first, highway A second
				if (words_left_ff == 2'b10)
					host_rdata_ff <= fs_seen_ff ? code_b : `CLK_ABSENT_CODE;
				else if (words_left_ff == 2'b01)
					host_rdata_ff <= fs_seen_ff ? code_a : `CLK_ABSENT_CODE;
				else
					host_rdata_ff <= 16'h0000;
			end
		end
	end
endmodule // host_port_command_check

// file: rtl/host_port_regs.vh
// Overview of operation
// - command 0xFD04 stores 0x04 in interface config and drives wait pin high
// - command 0xFD06 stores 0x06 in interface config and drives wait pin low
// - idle command register read returns 0x0002; bit 1 mirrors interrupt pin
// - in 8-bit mode command register is read as two bytes, one per read
// - command 0xFEzz loads page register; page shows in upper byte of command register reads
// - command 0x8801 then two data reads return one clock word each
// - first word is redundant highway clock code, second highway A code
// - word reads 0x92FB when its clock is absent
// - debug port held in reset while its active-low test reset is low
// - redundant inputs tied to highway B let the detector supervise highway B
// - interrupt pin level, active low; indication read clears; stays low if pending
//
// Purpose: constants for the host port command check block
// Assumes: included by bare name
// Notes:   command codes are 16-bit words written to the command location
`ifndef HOST_PORT_REGS_VH
`define HOST_PORT_REGS_VH
`define ADDR_CMD          1'b0
`define ADDR_DATA         1'b1
`define CMD_RESET_VAL     16'h0002
`define CMD_CFG_HI        8'hFD
`define CMD_PAGE_HI       8'hFE
`define CMD_CLKSEL        16'h8801
`define CFG_WAIT_HIGH     8'h04
`define CFG_WAIT_LOW      8'h06
`define CLK_ABSENT_CODE   16'h92FB
`define CMD_INT_BIT       1
`define CLK_TIMEOUT_NS    4000
`define CLK_PERIOD_NS     5
`define CLK_TIMEOUT_CYC   (`CLK_TIMEOUT_NS / `CLK_PERIOD_NS)
`define RATE_WINDOW_CYC   4000
`endif

// file: tb/host_model.sv
// Purpose: host processor issuing commands and reads
// Assumes: answer stands one cycle after the read strobe
// Notes:   released data bus shows the inverse of its last value
`timescale 1ns/10ps
module host_model (
	input wire		clk,
	input wire		host_rvalid_ff,
	input wire [15:0]	host_rdata_ff,
	output reg		host_addr = 1'b0,
	output reg		host_wr = 1'b0,
	output reg		host_rd = 1'b0,
	output reg [15:0]	host_wdata = 16'h0000
);
	task wr(input logic a, input logic [15:0] d);
		@(posedge clk);
		host_addr <= a;
		host_wdata <= d;
		host_wr <= 1'b1;
		@(posedge clk);
		host_wr <= 1'b0;
		host_wdata <= ~d;
	endtask
	task rd(input logic a, output logic [15:0] d);
		@(posedge clk);
		host_addr <= a;
		host_rd <= 1'b1;
		@(posedge clk);
		host_rd <= 1'b0;
		@(negedge clk);
		d = host_rvalid_ff ? host_rdata_ff : 16'hxxxx;
	endtask
endmodule // host_model

// file: tb/host_port_command_check_properties.sv
// Purpose: port-level properties of the host command block
// Assumes: single clk domain, reset synchronous active high
// Notes:   bound into every instance of the block
`timescale 1ns/10ps
module hpc_props (
	input wire		clk,
	input wire		reset,
	input wire		host_addr,
	input wire		host_wr,
	input wire		host_rd,
	input wire [15:0]	host_wdata,
	input wire [15:0]	host_rdata_ff,
	input wire		host_rvalid_ff,
	input wire		host_wait_pin,
	input wire		host_int_n,
	input wire		int_pending,
	input wire		int_ind_read,
	input wire [15:0]	other_cmd_ff,
	input wire		other_cmd_valid_ff,
	input wire		test_reset_n,
	input wire		debug_reset,
	input wire [7:0]	page_ff,
	input wire [7:0]	if_config_ff,
	input wire		bus_8bit
);
	wire cw = host_wr && !host_addr;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	read_latency_a: assert property (host_rd |=> host_rvalid_ff)
		else $error("read not answered next cycle");
	wait_high_a: assert property (cw && host_wdata == 16'hFD04 |=> host_wait_pin && if_config_ff == 8'h04)
		else $error("wait high command failed");
	wait_low_a: assert property (cw && host_wdata == 16'hFD06 |=> !host_wait_pin && if_config_ff == 8'h06)
		else $error("wait low command failed");
	page_load_a: assert property (cw && host_wdata[15:8] == 8'hFE |=> page_ff == $past(host_wdata[7:0]))
		else $error("page not loaded");
	cmd_read_a: assert property (host_rd && !host_addr && !bus_8bit
		|=> host_rdata_ff == {$past(page_ff), 6'h00, $past(host_int_n), 1'b0}) else $error("command read wrong");
	int_level_a: assert property (host_int_n != int_pending)
		else $error("interrupt pin wrong level");
	debug_hold_a: assert property (!test_reset_n [*3] |-> debug_reset)
		else $error("debug port left reset");
	ind_read_a: assert property (int_ind_read |-> host_rd && host_addr)
		else $error("indication read without data read");
	pass_on_a: assert property (cw && host_wdata[15:8] != 8'hFD && host_wdata[15:8] != 8'hFE
		|=> other_cmd_valid_ff && other_cmd_ff == $past(host_wdata)) else $error("command not passed on");
endmodule // hpc_props
bind host_port_command_check hpc_props chk_u (.*);

// file: tb/host_port_command_check_tb.sv
// Purpose: directed checks of the host command block
// Assumes: host_model drives the host strobes
// Notes:   clock inputs grounded, so both words read the absent code
`timescale 1ns/10ps
module host_port_command_check_tb;
	reg		clk = 1'b0;
	reg		reset = 1'b1;
	reg [2:0]	config_pins = 3'h0;
	reg		int_pending = 1'b0;
	reg		test_reset_n = 1'b1;
	reg [15:0]	v;
	integer		errors = 0;
	integer		n_tests = 0;
	wire [15:0]	host_wdata, host_rdata_ff, other_cmd_ff;
	wire [7:0]	page_ff, if_config_ff;
	wire		host_addr, host_wr, host_rd, host_rvalid_ff, host_wait_pin, host_int_n;
	wire		int_ind_read, other_cmd_valid_ff, debug_reset, bus_8bit;
	always #2.5 clk = ~clk;
	host_model host_u (.*);
	host_port_command_check dut_u (.*, .highway_a_clock_in(1'b0), .redundant_highway_clock_in(1'b0),
		.redundant_highway_frame_in(1'b0));
	task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_tests = n_tests + 1;
		if (seen !== exp) begin
			errors = errors + 1;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task complete_run;
		if (errors == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task do_reset(input logic [2:0] straps);
		@(posedge clk);
		reset <= 1'b1;
		config_pins <= straps;
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	initial begin
		#20000;
		errors = errors + 1;
		complete_run;
	end
	initial begin
		do_reset(3'h0);
		host_u.rd(1'b0, v);
		check("idle", v, 16'h0002);
		host_u.wr(1'b0, 16'hFD04);
		@(negedge clk);
		check("wait_hi", {if_config_ff, 7'h00, host_wait_pin}, 16'h0401);
		host_u.wr(1'b0, 16'hFD06);
		@(negedge clk);
		check("wait_lo", {if_config_ff, 7'h00, host_wait_pin}, 16'h0600);
		host_u.wr(1'b0, 16'hFEAA);
		host_u.rd(1'b0, v);
		check("page", v, 16'hAA02);
		@(posedge clk);
		int_pending <= 1'b1;
		host_u.rd(1'b0, v);
		check("int", v, 16'hAA00);
		int_pending <= 1'b0;
		host_u.wr(1'b0, 16'h8801);
		@(negedge clk);
		check("pass", other_cmd_ff, 16'h8801);
		host_u.rd(1'b1, v);
		check("word_b", v, 16'h92FB);
		host_u.rd(1'b1, v);
		check("word_a", v, 16'h92FB);
		host_u.rd(1'b1, v);
		check("unarmed", v, 16'h0000);
		@(posedge clk);
		test_reset_n <= 1'b0;
		repeat (3) @(posedge clk);
		test_reset_n <= 1'b1;
		@(negedge clk);
		check("dbg", {15'h0000, debug_reset}, 16'h0001);
		repeat (3) @(posedge clk);
		@(negedge clk);
		check("dbg_off", {15'h0000, debug_reset}, 16'h0000);
		do_reset(3'h1);
		host_u.wr(1'b0, 16'hFE55);
		host_u.rd(1'b0, v);
		check("lo", {7'h00, bus_8bit, v[7:0]}, 16'h0102);
		host_u.rd(1'b0, v);
		check("hi", {8'h00, v[7:0]}, 16'h0055);
		complete_run;
	end
endmodule // host_port_command_check_tb
